/* core/uemt_gate.sv */
// Status-and-mask gate for one endpoint, registered output
`timescale 1ns/1ps
module uemt_gate
   import uemt_pkg::*;
(
   input  wire logic        aclk,     // Clock
   input  wire logic        aresetn,  // Sync reset, low
   input  wire logic        ce,       // Clock enable
   input  wire logic [31:0] status,   // Endpoint status
   input  wire logic [31:0] mask,     // One unmasks
   output logic             hit       // Any unmasked status
);
   logic hit_d;
   logic hit_q;

   always_comb begin
      hit_d = |(status & mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hit_q <= 1'b0;
      end else if (ce) begin
         hit_q <= hit_d;
      end
   end

   assign hit = hit_q;
endmodule

/* core/uemt_pkg.sv */
// Package: register map, field layout, reset values and carriers
package uemt_pkg;

   // ======================================================================
   // Register byte offsets
   localparam logic [11:0] THR_CTRL_OFS  = 12'h830;
   localparam logic [11:0] EMPTY_MSK_OFS = 12'h834;
   localparam logic [11:0] SUMMARY_OFS   = 12'h838;
   localparam logic [11:0] SUM_MSK_OFS   = 12'h83C;
   localparam logic [11:0] IN_MSK_BASE   = 12'h840;
   localparam logic [11:0] OUT_MSK_BASE  = 12'h880;
   localparam logic [11:0] EP0_CTRL_OFS  = 12'h900;
   localparam logic [11:0] IRQ_OUT_OFS   = 12'h904;

   // ======================================================================
   // Threshold control fields, EP0 enable bit and endpoint count
   localparam int PARK_BIT     = 27;
   localparam int RX_LEN_LSB   = 17;
   localparam int RX_LEN_MSB   = 25;
   localparam int RX_EN_BIT    = 16;
   localparam int RATIO_LSB    = 11;
   localparam int RATIO_MSB    = 12;
   localparam int TX_LEN_LSB   = 2;
   localparam int TX_LEN_MSB   = 10;
   localparam int ISO_EN_BIT   = 1;
   localparam int BULK_EN_BIT  = 0;
   localparam int EP_ENA_BIT   = 31;
   localparam int NUM_EP       = 16;

   localparam logic [31:0] THR_CTRL_RST  = 32'h0810_0020;
   localparam logic [31:0] THR_CTRL_WMSK = 32'h0BFF_1FFF;
   localparam logic [31:0] IN_MSK_WMSK   = 32'h0000_237F;
   localparam logic [31:0] OUT_MSK_WMSK  = 32'h0000_735F;
   localparam logic [31:0] EMPTY_WMSK    = 32'h0000_FFFF;
   localparam logic [31:0] EP0_USB_ACT   = 32'h0000_8000;
   localparam logic [31:0] EP0_EVT_MSK   = 32'h0000_0003;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ======================================================================
   // Carriers
   typedef struct packed {
      logic        park_en;
      logic [8:0]  rx_len;
      logic        rx_en;
      logic [1:0]  ratio;
      logic [8:0]  tx_len;
      logic        iso_en;
      logic        bulk_en;
   } uemt_thr_type;

   typedef struct packed {
      logic [31:0] data;
      logic [1:0]  resp;
   } uemt_rd_type;

endpackage

/* core/uemt_top.sv */
// Threshold control, per-endpoint masks and EP0 enable over AXI4-Lite
`timescale 1ns/1ps
module uemt_top
   import uemt_pkg::*;
#(
   parameter bit MULTI_PROC = 1'b1   // Multi-processor interrupt option
)(
   input  wire logic        aclk,            // Clock, 125 MHz
   input  wire logic        aresetn,         // Sync reset, low
   input  wire logic        ce,              // Clock enable
   input  wire logic [11:0] s_awaddr,        // Write address
   input  wire logic        s_awvalid,       // Write address valid
   output logic             s_awready,       // Write address ready
   input  wire logic [31:0] s_wdata,         // Write data
   input  wire logic [3:0]  s_wstrb,         // Write strobes
   input  wire logic        s_wvalid,        // Write data valid
   output logic             s_wready,        // Write data ready
   output logic [1:0]       s_bresp,         // Write response
   output logic             s_bvalid,        // Write response valid
   input  wire logic        s_bready,        // Write response ready
   input  wire logic [11:0] s_araddr,        // Read address
   input  wire logic        s_arvalid,       // Read address valid
   output logic             s_arready,       // Read address ready
   output logic [31:0]      s_rdata,         // Read data
   output logic [1:0]       s_rresp,         // Read response
   output logic             s_rvalid,        // Read data valid
   input  wire logic        s_rready,        // Read data ready
   input  wire logic [15:0] in_status_hit,   // IN status nonzero per ep
   input  wire logic [15:0] out_status_hit,  // OUT status nonzero per ep
   input  wire logic [31:0] ep0_in_status,   // EP0 IN status bits
   input  wire logic        ep0_disable_evt, // EP0 IN disabled pending
   input  wire logic        ep0_done_evt,    // EP0 IN xfer done pending
   input  wire logic        in_token_valid,  // IN token seen on USB
   input  wire logic [3:0]  in_token_ep,     // Its endpoint number
   output uemt_thr_type     thr_cfg,         // Threshold settings
   output logic [8:0]       bus_tx_thr,      // Derived bus threshold
   output logic             park_valid,      // Arbiter parked
   output logic [3:0]       park_ep,         // Parked endpoint
   output logic             ep0_in_enable,   // EP0 IN enable bit
   output logic             ep0_evt_raise,   // EP0 event may be raised
   output logic             ep0_irq,         // EP0 masked interrupt
   output logic [31:0]      summary_irq      // Masked summary per ep
);
   // ======================================================================
   // Register state
   uemt_thr_type thr_q, thr_d;
   logic [15:0] empty_q, empty_d;
   logic [31:0] smsk_q, smsk_d;
   logic [31:0] in_msk_q  [NUM_EP];
   logic [31:0] out_msk_q [NUM_EP];
   logic [31:0] in_msk_d  [NUM_EP];
   logic [31:0] out_msk_d [NUM_EP];
   logic        ena_q, ena_d;
   logic        rais_q, rais_d;
   logic [31:0] sum_q, sum_d;
   logic [31:0] sirq_q, sirq_d;
   logic [8:0]  bthr_q, bthr_d;
   logic        pv_q, pv_d;
   logic [3:0]  pe_q, pe_d;

   // Bus channel state
   logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
   logic [11:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d;
   logic [3:0]  ws_q, ws_d;
   logic [1:0]  bresp_q, bresp_d;
   uemt_rd_type rd_q, rd_d;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st,
                                          input logic [31:0] wm);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r & wm;
   endfunction

   function automatic logic [31:0] thr_word(input uemt_thr_type t);
      logic [31:0] r;
      r = '0;
      r[PARK_BIT] = t.park_en;
      r[RX_LEN_MSB:RX_LEN_LSB] = t.rx_len;
      r[RX_EN_BIT] = t.rx_en;
      r[RATIO_MSB:RATIO_LSB] = t.ratio;
      r[TX_LEN_MSB:TX_LEN_LSB] = t.tx_len;
      r[ISO_EN_BIT] = t.iso_en;
      r[BULK_EN_BIT] = t.bulk_en;
      return r;
   endfunction

   // Decode used by both channels; summary, summary mask and endpoint masks vanish without the option
   function automatic logic mapped(input logic [11:0] a);
      logic m;
      m = (a == THR_CTRL_OFS) || (a == EMPTY_MSK_OFS) ||
          (a == EP0_CTRL_OFS) || (a == IRQ_OUT_OFS);
      if (MULTI_PROC) begin
         m = m || (a == SUMMARY_OFS) || (a == SUM_MSK_OFS) ||
             (a[11:6] == IN_MSK_BASE[11:6]) ||
             (a[11:6] == OUT_MSK_BASE[11:6]);
      end
      return m;
   endfunction

   logic        wr_go;
   logic [3:0]  wr_ep;
   logic [31:0] thr_w;
   logic [31:0] ep0_hit;

   // ======================================================================
   // Next-state logic
   always_comb begin
      thr_d   = thr_q;
      empty_d = empty_q;
      smsk_d  = smsk_q;
      in_msk_d  = in_msk_q;
      out_msk_d = out_msk_q;
      ena_d   = ena_q;
      aw_d = aw_q;  w_d = w_q;  b_d = b_q;  r_d = r_q;
      awa_d = awa_q;  wd_d = wd_q;  ws_d = ws_q;
      bresp_d = bresp_q;
      rd_d = rd_q;
      if (s_awvalid && !aw_q && !b_q) begin
         aw_d  = 1'b1;
         awa_d = {s_awaddr[11:2], 2'b00};
      end
      if (s_wvalid && !w_q && !b_q) begin
         w_d  = 1'b1;
         wd_d = s_wdata;
         ws_d = s_wstrb;
      end
      wr_go = aw_q && w_q && !b_q;
      wr_ep = awa_q[5:2];
      thr_w = merge(thr_word(thr_q), wd_q, ws_q, THR_CTRL_WMSK);
      if (wr_go) begin
         aw_d = 1'b0;
         w_d  = 1'b0;
         b_d  = 1'b1;
         bresp_d = mapped(awa_q) ? RESP_OKAY : RESP_SLVERR;
         if (awa_q == THR_CTRL_OFS) begin
            thr_d.park_en = thr_w[PARK_BIT];
            thr_d.rx_len  = thr_w[RX_LEN_MSB:RX_LEN_LSB];
            thr_d.rx_en   = thr_w[RX_EN_BIT];
            thr_d.ratio   = thr_w[RATIO_MSB:RATIO_LSB];
            thr_d.tx_len  = thr_w[TX_LEN_MSB:TX_LEN_LSB];
            thr_d.iso_en  = thr_w[ISO_EN_BIT];
            thr_d.bulk_en = thr_w[BULK_EN_BIT];
         end
         if (awa_q == EMPTY_MSK_OFS) begin
            empty_d = 16'(merge({16'h0000, empty_q}, wd_q, ws_q,
                                EMPTY_WMSK));
         end
         if (MULTI_PROC && awa_q == SUM_MSK_OFS) begin
            smsk_d = merge(smsk_q, wd_q, ws_q, 32'hFFFF_FFFF);
         end
         if (MULTI_PROC && awa_q[11:6] == IN_MSK_BASE[11:6]) begin
            in_msk_d[wr_ep] = merge(in_msk_q[wr_ep], wd_q, ws_q,
                                    IN_MSK_WMSK);
         end
         if (MULTI_PROC && awa_q[11:6] == OUT_MSK_BASE[11:6]) begin
            out_msk_d[wr_ep] = merge(out_msk_q[wr_ep], wd_q, ws_q,
                                     OUT_MSK_WMSK);
         end
         if (awa_q == EP0_CTRL_OFS && ws_q[3] && wd_q[EP_ENA_BIT]) begin
            ena_d = 1'b1;
         end
      end
      // Hardware clear wins only if already enabled: if a write sets it from disabled with an event pending, the event is raised while enabled
      if (ena_q && (ep0_disable_evt || ep0_done_evt)) begin
         ena_d = 1'b0;
      end
      if (b_q && s_bready) begin
         b_d = 1'b0;
      end
      if (s_arvalid && !r_q) begin
         r_d = 1'b1;
         rd_d.resp = mapped(s_araddr) ? RESP_OKAY : RESP_SLVERR;
         rd_d.data = 32'h0000_0000;
         if (s_araddr[11:6] == IN_MSK_BASE[11:6] && MULTI_PROC) begin
            rd_d.data = in_msk_q[s_araddr[5:2]];
         end
         if (s_araddr[11:6] == OUT_MSK_BASE[11:6] && MULTI_PROC) begin
            rd_d.data = out_msk_q[s_araddr[5:2]];
         end
         case (s_araddr[11:2])
            THR_CTRL_OFS[11:2]:  rd_d.data = thr_word(thr_q);
            EMPTY_MSK_OFS[11:2]: rd_d.data = {16'h0000, empty_q};
            SUMMARY_OFS[11:2]:   rd_d.data = MULTI_PROC ? sum_q : '0;
            SUM_MSK_OFS[11:2]:   rd_d.data = MULTI_PROC ? smsk_q : '0;
            EP0_CTRL_OFS[11:2]:  rd_d.data = {ena_q, 31'h0} | EP0_USB_ACT;
            IRQ_OUT_OFS[11:2]:   rd_d.data = sirq_q;
            default: ;
         endcase
      end else if (r_q && s_rready) begin
         r_d = 1'b0;
      end
   end

   // ======================================================================
   // Interrupt summary, arbiter park and bus threshold
   always_comb begin
      sum_d  = {out_status_hit, in_status_hit};
      sirq_d = MULTI_PROC ? (sum_q & smsk_q) : '0;
      // Ratio shifts MAC threshold down, never exceeding it
      bthr_d = thr_q.tx_len >> thr_q.ratio;
      pv_d = pv_q;
      pe_d = pe_q;
      if (!(thr_q.iso_en || thr_q.bulk_en) || !thr_q.park_en) begin
         pv_d = 1'b0;
      end else if (in_token_valid) begin
         pv_d = 1'b1;
         pe_d = in_token_ep;
      end
      rais_d = !ena_q && (ep0_disable_evt || ep0_done_evt);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         thr_q   <= '{park_en: 1'b1, rx_len: 9'h008, rx_en: 1'b0,
                      ratio: 2'h0, tx_len: 9'h008, iso_en: 1'b0,
                      bulk_en: 1'b0};
         empty_q <= '0;
         smsk_q  <= '0;
         for (int i = 0; i < NUM_EP; i++) begin
            in_msk_q[i]  <= '0;
            out_msk_q[i] <= '0;
         end
         ena_q  <= 1'b0;
         rais_q <= 1'b0;
         sum_q  <= '0;
         sirq_q <= '0;
         bthr_q <= 9'h008;
         pv_q   <= 1'b0;
         pe_q   <= 4'h0;
         aw_q <= 1'b0;  w_q <= 1'b0;  b_q <= 1'b0;  r_q <= 1'b0;
         awa_q <= '0;  wd_q <= '0;  ws_q <= '0;
         bresp_q <= RESP_OKAY;
         rd_q <= '0;
      end else if (ce) begin
         thr_q   <= thr_d;
         empty_q <= empty_d;
         smsk_q  <= smsk_d;
         in_msk_q  <= in_msk_d;
         out_msk_q <= out_msk_d;
         ena_q  <= ena_d;
         rais_q <= rais_d;
         sum_q  <= sum_d;
         sirq_q <= sirq_d;
         bthr_q <= bthr_d;
         pv_q   <= pv_d;
         pe_q   <= pe_d;
         aw_q <= aw_d;  w_q <= w_d;  b_q <= b_d;  r_q <= r_d;
         awa_q <= awa_d;  wd_q <= wd_d;  ws_q <= ws_d;
         bresp_q <= bresp_d;
         rd_q <= rd_d;
      end
   end

   // EP0 IN status gated by its own mask
   assign ep0_hit = ep0_in_status & (MULTI_PROC ? in_msk_q[0] : '0);

   uemt_gate u_ep0_gate (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .status  (ep0_hit),
      .mask    (32'hFFFF_FFFF),
      .hit     (ep0_irq)
   );

   // ======================================================================
   // Outputs
   assign s_awready     = !aw_q && !b_q;
   assign s_wready      = !w_q && !b_q;
   assign s_bvalid      = b_q;
   assign s_bresp       = bresp_q;
   assign s_arready     = !r_q;
   assign s_rvalid      = r_q;
   assign s_rdata       = rd_q.data;
   assign s_rresp       = rd_q.resp;
   assign thr_cfg       = thr_q;
   assign bus_tx_thr    = bthr_q;
   assign park_valid    = pv_q;
   assign park_ep       = pe_q;
   assign ep0_in_enable = ena_q;
   assign ep0_evt_raise = rais_q;
   assign summary_irq   = sirq_q;

   // ======================================================================
   // Checks
   chk_park_drop: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (ce && !thr_q.park_en) |=> !pv_q)
      else $error("park held without enable");
   chk_bus_thr_le: assert property (@(posedge aclk)
      disable iff (!aresetn)
      bthr_q <= thr_q.tx_len || $changed(thr_q.tx_len))
      else $error("bus threshold above usb threshold");
   chk_ep0_clear: assert property (@(posedge aclk)
      disable iff (!aresetn)
      rais_q |-> !ena_q)
      else $error("ep0 event raised while enabled");
   chk_summary_follow: assert property (@(posedge aclk)
      disable iff (!aresetn)
      ce |=> sum_q == $past({out_status_hit, in_status_hit}))
      else $error("summary not following status");
   chk_mask_gate: assert property (@(posedge aclk)
      disable iff (!aresetn)
      ce |=> sirq_q == ($past(sum_q) & $past(smsk_q)))
      else $error("summary irq not gated by mask");
   chk_rx_len_rst: assert property (@(posedge aclk)
      $rose(aresetn) |-> thr_q.rx_len == 9'h008 && thr_q.tx_len == 9'h008)
      else $error("threshold lengths not reset to eight");
endmodule

/* testbench/tb_usb_dev_ep_irq_mask_threshold.sv */
// Self-checking bench for thresholds, endpoint masks and EP0 enable
`timescale 1ns/1ps
module tb_usb_dev_ep_irq_mask_threshold;
   import uemt_pkg::*;
   // ======================================================================
   // Signals
   logic         aclk, aresetn, ce;
   logic [11:0]  s_awaddr, s_araddr;
   logic [31:0]  s_wdata, s_rdata, ep0_in_status, summary_irq;
   logic [3:0]   s_wstrb, in_token_ep, park_ep;
   logic         s_awvalid, s_awready, s_wvalid, s_wready;
   logic         s_bvalid, s_bready, s_arvalid, s_arready;
   logic         s_rvalid, s_rready, park_valid, in_token_valid;
   logic [1:0]   s_bresp, s_rresp;
   logic [15:0]  in_status_hit, out_status_hit;
   logic         ep0_disable_evt, ep0_done_evt, ep0_in_enable;
   logic         ep0_evt_raise, ep0_irq;
   logic [8:0]   bus_tx_thr;
   uemt_thr_type thr_cfg;
   int           mismatches, check_count;

   uemt_top u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
      .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
      .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
      .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
      .s_rvalid(s_rvalid), .s_rready(s_rready),
      .in_status_hit(in_status_hit), .out_status_hit(out_status_hit),
      .ep0_in_status(ep0_in_status), .ep0_disable_evt(ep0_disable_evt),
      .ep0_done_evt(ep0_done_evt), .in_token_valid(in_token_valid),
      .in_token_ep(in_token_ep), .thr_cfg(thr_cfg),
      .bus_tx_thr(bus_tx_thr), .park_valid(park_valid),
      .park_ep(park_ep), .ep0_in_enable(ep0_in_enable),
      .ep0_evt_raise(ep0_evt_raise), .ep0_irq(ep0_irq),
      .summary_irq(summary_irq));

   uemt_host_model u_host (.aclk(aclk), .ep0_evt_raise(ep0_evt_raise),
      .in_status_hit(in_status_hit), .out_status_hit(out_status_hit),
      .ep0_in_status(ep0_in_status), .ep0_disable_evt(ep0_disable_evt),
      .ep0_done_evt(ep0_done_evt), .in_token_valid(in_token_valid),
      .in_token_ep(in_token_ep));

   initial aclk = 1'b0;
   always #4 aclk = ~aclk;

   // ======================================================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic axw(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
      int n;
      logic ad;
      logic wd;
      logic awr;
      logic wr;
      ad = 1'b0;
      wd = 1'b0;
      n = 0;
      s_awaddr <= a;
      s_wdata <= d;
      s_wstrb <= s;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      // Readies sampled mid-cycle, so the handshake edge is unambiguous
      while (!(ad && wd) && n < 64) begin
         @(negedge aclk);
         awr = s_awready;
         wr = s_wready;
         @(posedge aclk);
         n++;
         if (!ad && awr) begin
            ad = 1'b1;
            s_awvalid <= 1'b0;
         end
         if (!wd && wr) begin
            wd = 1'b1;
            s_wvalid <= 1'b0;
         end
      end
      do begin
         @(negedge aclk);
         n++;
      end while (!s_bvalid && n < 64);
      chk({31'h0, s_bvalid}, 32'h1, "write answer");
      chk({30'h0, s_bresp}, {30'h0, er}, "bresp");
      @(posedge aclk);
   endtask

   task automatic axr(input logic [11:0] a, input logic [31:0] exp,
                      input logic [1:0] er);
      int n;
      n = 0;
      s_araddr <= a;
      s_arvalid <= 1'b1;
      do begin
         @(negedge aclk);
         n++;
      end while (!s_arready && n < 64);
      @(posedge aclk);
      s_arvalid <= 1'b0;
      do begin
         @(negedge aclk);
         n++;
      end while (!s_rvalid && n < 64);
      chk({31'h0, s_rvalid}, 32'h1, "read answer");
      chk({30'h0, s_rresp}, {30'h0, er}, "rresp");
      if (er === RESP_OKAY) chk(s_rdata, exp, "rdata");
      @(posedge aclk);
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ======================================================================
   // Scenarios
   task automatic t_reset_values;
      axr(THR_CTRL_OFS, THR_CTRL_RST, RESP_OKAY);
      chk({23'h0, bus_tx_thr}, 32'h8, "bus thr");
      axr(EMPTY_MSK_OFS, 32'h0, RESP_OKAY);
      axr(SUM_MSK_OFS, 32'h0, RESP_OKAY);
      axr(EP0_CTRL_OFS, EP0_USB_ACT, RESP_OKAY);
      for (int n = 0; n < NUM_EP; n++) begin
         axr(IN_MSK_BASE + 12'(4 * n), 32'h0, RESP_OKAY);
         axr(OUT_MSK_BASE + 12'(4 * n), 32'h0, RESP_OKAY);
      end
   endtask

   // Software keeps both lengths at eight words or more
   task automatic t_ratio;
      logic [31:0] v;
      for (int r = 0; r < 4; r++) begin
         v = 32'h0821_0103 | (r << 11);
         axw(THR_CTRL_OFS, v | 32'h0400_E000, 4'hF,
             RESP_OKAY);
         axr(THR_CTRL_OFS, v, RESP_OKAY);
         repeat (2) @(posedge aclk);
         chk({8'h0, thr_cfg}, {8'h0, v[27], v[25:16], v[12:0]}, "cfg");
         chk({23'h0, bus_tx_thr}, 32'd64 >> r, "bus thr");
      end
   endtask

   task automatic t_masks;
      axw(IN_MSK_BASE + 12'h3C, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      axr(IN_MSK_BASE + 12'h3C, IN_MSK_WMSK, RESP_OKAY);
      axw(OUT_MSK_BASE + 12'hC, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      axr(OUT_MSK_BASE + 12'hC, OUT_MSK_WMSK, RESP_OKAY);
      axw(EMPTY_MSK_OFS, 32'hFFFF_FFFF, 4'h1, RESP_OKAY);
      axr(EMPTY_MSK_OFS, 32'h0000_00FF, RESP_OKAY);
      axw(12'h8C0, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
      axr(12'h8C0, 32'h0, RESP_SLVERR);
   endtask

   task automatic t_summary;
      u_host.levels(16'h0004, 16'h0020, 32'h0);
      repeat (3) @(posedge aclk);
      axr(SUMMARY_OFS, 32'h0020_0004, RESP_OKAY);
      chk(summary_irq, 32'h0, "masked summary");
      axw(SUM_MSK_OFS, 32'h0020_0000, 4'hF, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk(summary_irq, 32'h0020_0000, "unmasked summary");
      axr(IRQ_OUT_OFS, 32'h0020_0000, RESP_OKAY);
      axr(SUMMARY_OFS, 32'h0020_0004, RESP_OKAY);
      u_host.levels(16'h0, 16'h0, 32'h1);
      axw(IN_MSK_BASE, 32'h2, 4'hF, RESP_OKAY);
      repeat (4) @(posedge aclk);
      axr(SUMMARY_OFS, 32'h0, RESP_OKAY);
      chk({31'h0, ep0_irq}, 32'h0, "ep0 irq masked");
      axw(IN_MSK_BASE, 32'h1, 4'hF, RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk({31'h0, ep0_irq}, 32'h1, "ep0 irq open");
   endtask

   task automatic t_park;
      logic [31:0] cfg [4] = '{32'h0810_0021, 32'h0810_0022,
                               32'h0010_0021, 32'h0810_0020};
      logic seen;
      for (int i = 0; i < 4; i++) begin
         axw(THR_CTRL_OFS, cfg[i], 4'hF, RESP_OKAY);
         repeat (2) @(posedge aclk);
         u_host.token(4'(4 + i));
         seen = 1'b0;
         repeat (6) begin
            @(posedge aclk);
            if (park_valid === 1'b1 && park_ep === 4'(4 + i)) seen = 1'b1;
         end
         chk({31'h0, seen}, {31'h0, i < 2}, "park");
      end
   endtask

   task automatic t_ep0;
      int n;
      for (int k = 0; k < 2; k++) begin
         axw(EP0_CTRL_OFS, 32'h8000_0000, 4'hF, RESP_OKAY);
         chk({31'h0, ep0_in_enable}, 32'h1, "ep0 enable");
         axr(EP0_CTRL_OFS, 32'h8000_8000, RESP_OKAY);
         u_host.raise(k[0]);
         n = 0;
         while (ep0_evt_raise !== 1'b1 && n < 20) begin
            @(negedge aclk);
            n++;
         end
         chk({31'h0, ep0_in_enable}, 32'h0, "enable at event");
         chk({31'h0, ep0_evt_raise}, 32'h1, "event raised");
      end
   endtask

   // ======================================================================
   // Main sequence
   initial begin
      mismatches = 0;
      check_count = 0;
      aresetn = 1'b0;
      ce = 1'b1;
      s_awaddr = 12'h0;
      s_araddr = 12'h0;
      s_wdata = 32'h0;
      s_wstrb = 4'hF;
      // Answer channels always ready: no toggling between transfers
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h05;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset_values();
      t_ratio();
      t_masks();
      t_summary();
      t_park();
      t_ep0();
      conclude();
   end

   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      conclude();
   end
endmodule

/* testbench/uemt_host_model.sv */
// Far-side model: endpoint status levels, IN tokens and EP0 events
`timescale 1ns/1ps
module uemt_host_model (
   input  wire logic        aclk,            // Clock
   input  wire logic        ep0_evt_raise,   // EP0 event taken by core
   output logic [15:0]      in_status_hit,   // IN status levels
   output logic [15:0]      out_status_hit,  // OUT status levels
   output logic [31:0]      ep0_in_status,   // EP0 IN status bits
   output logic             ep0_disable_evt, // EP0 disable pending
   output logic             ep0_done_evt,    // EP0 done pending
   output logic             in_token_valid,  // Token pulse
   output logic [3:0]       in_token_ep      // Token endpoint
);
   // ======================================================================
   // Levels
   initial begin
      in_status_hit = 16'h0000;
      out_status_hit = 16'h0000;
      ep0_in_status = 32'h0000_0000;
      ep0_disable_evt = 1'b0;
      ep0_done_evt = 1'b0;
      in_token_valid = 1'b0;
      in_token_ep = 4'hA;
   end

   task automatic levels(input logic [15:0] i, input logic [15:0] o,
                         input logic [31:0] s);
      @(posedge aclk);
      in_status_hit <= i;
      out_status_hit <= o;
      ep0_in_status <= s;
   endtask

   // ======================================================================
   // Tokens: the endpoint lines show a changed value once released
   task automatic token(input logic [3:0] e);
      @(posedge aclk);
      in_token_valid <= 1'b1;
      in_token_ep <= e;
      @(posedge aclk);
      in_token_valid <= 1'b0;
      in_token_ep <= ~e;
   endtask

   task automatic raise(input logic dis);
      @(posedge aclk);
      ep0_disable_evt <= dis;
      ep0_done_evt <= !dis;
   endtask

   // Pending event is dropped once the core has raised it
   always @(posedge aclk) begin
      if (ep0_evt_raise) begin
         ep0_disable_evt <= 1'b0;
         ep0_done_evt <= 1'b0;
      end
   end
endmodule
